// ### inc/hbd_pkg.sv
/*
  Shared constants and types for the disk board host-bus glue.
  Assumes a 100 MHz system clock and an APB master with 32-bit data.
*/
package hbd_pkg;

  // APB register byte offsets.
  localparam logic [11:0] CFG_OFS  = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;

  // Configuration field positions and width inside the word.
  localparam int CFG_DMA_LSB = 0;
  localparam int CFG_IRQ_LSB = 2;
  localparam int CFG_MST_BIT = 4;
  localparam int CFG_W       = 5;

  // Status field positions inside the word.
  localparam int STAT_ST_LSB  = 0;
  localparam int STAT_DRV_LSB = 3;
  localparam int STAT_FLP_BIT = 5;
  localparam int STAT_WIN_BIT = 6;

  // Host DMA channel routing codes; the fourth code routes nothing.
  localparam logic [1:0] DMA_CH5 = 2'h0;
  localparam logic [1:0] DMA_CH6 = 2'h1;
  localparam logic [1:0] DMA_CH7 = 2'h2;

  // Host interrupt routing codes.
  localparam logic [1:0] IRQ_NONE = 2'h0;
  localparam logic [1:0] IRQ_14   = 2'h1;
  localparam logic [1:0] IRQ_6    = 2'h2;

  // Host I/O window in which the controller answers, both ends included.
  localparam logic [9:0] IO_WIN_LO = 10'h100;
  localparam logic [9:0] IO_WIN_HI = 10'h110;

  typedef struct packed {
    logic       mst_en;
    logic [1:0] irq_sel;
    logic [1:0] dma_sel;
  } hbd_cfg_t;

  localparam hbd_cfg_t CFG_RST = '{mst_en: 1'b1, irq_sel: IRQ_NONE, dma_sel: DMA_CH7};

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } hbd_apb_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ  = 3'b010,
    ST_OWN  = 3'b100
  } hbd_state_t;

  // Two-to-four decode with enable; all outputs low when disabled.
  function automatic logic [3:0] hbd_dec24(input logic en, input logic [1:0] n);
    logic [3:0] d;
    d = 4'h0;
    d[n] = en;
    return d;
  endfunction

endpackage

// ### rtl/hbd_sep_ctl.sv
/*
  Disk-side glue: data separator clock and mode, read data select
  and drive select decode.
  Assumes oscillator and read data inputs are synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module hbd_sep_ctl (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       osc5_i,
  input  wire logic       osc8_i,
  input  wire logic [1:0] drv_num_i,
  input  wire logic       drv_en_i,
  input  wire logic [1:0] rd_hd_i,
  input  wire logic       rd_fd_i,
  output logic            sep_clk_o,
  output logic            sep_floppy_o,
  output logic            sep_rd_o,
  output logic [1:0]      hdd_sel_o,
  output logic [1:0]      fdd_sel_o
);
  import hbd_pkg::*;

  logic       osc8_q_ff;
  logic       div_ff;
  logic       clk_ff;
  logic       flp_ff;
  logic       rd_ff;
  logic [3:0] sel_ff;

  // Drives 2 and 3 are floppies, so the high drive bit picks the mode.
  wire       is_flp    = drv_num_i[1];
  wire       osc8_rise = osc8_i & ~osc8_q_ff;
  wire       rd_sel    = is_flp ? rd_fd_i : rd_hd_i[drv_num_i[0]];
  wire [3:0] sel_dec   = hbd_dec24(drv_en_i, drv_num_i);

  // The 8 MHz source is halved by toggling on each of its rising edges.
  // Switching source mid-period can give one short phase; the separator
  // must relock after a drive change anyway.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc8_q_ff <= 1'b0;
      div_ff    <= 1'b0;
      clk_ff    <= 1'b0;
      flp_ff    <= 1'b0;
      rd_ff     <= 1'b0;
      sel_ff    <= 4'h0;
    end else begin
      osc8_q_ff <= osc8_i;
      div_ff    <= div_ff ^ osc8_rise;
      clk_ff    <= is_flp ? div_ff : osc5_i;
      flp_ff    <= is_flp;
      rd_ff     <= rd_sel;
      sel_ff    <= sel_dec;
    end
  end

  // Drive 0 and 1 feed the hard disk selects, drive 2 and 3 the floppy.
  assign hdd_sel_o    = sel_ff[1:0];
  assign fdd_sel_o    = sel_ff[3:2];
  assign sep_clk_o    = clk_ff;
  assign sep_floppy_o = flp_ff;
  assign sep_rd_o     = rd_ff;

  // Checks on mode, clock source, read select and drive decode.
  sep_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drv_num_i == 2'h2 |=> sep_floppy_o)
    else $error("separator not in floppy mode for drive 2");
  hd_clock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !drv_num_i[1] |=> sep_clk_o == $past(osc5_i))
    else $error("hard disk clock not from 5 MHz source");
  div_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_flp && osc8_i && !osc8_q_ff |=> ##1 sep_clk_o != $past(sep_clk_o) || !$past(is_flp))
    else $error("floppy clock did not follow halved source");
  rd_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drv_num_i == 2'h1 |=> sep_rd_o == $past(rd_hd_i[1]))
    else $error("read data not from second hard disk");
  sel_onehot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0({fdd_sel_o, hdd_sel_o}))
    else $error("more than one drive selected");
  hd_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drv_en_i && drv_num_i == 2'h1 |=> hdd_sel_o == 2'b10 && fdd_sel_o == 2'b00)
    else $error("drive 1 not on hard disk select two");
  fd_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drv_en_i && drv_num_i == 2'h2 |=> fdd_sel_o == 2'b01 && hdd_sel_o == 2'b00)
    else $error("drive 2 not on floppy select zero");

endmodule

`default_nettype wire

// ### rtl/hbd_glue.sv
/*
  Host bus glue for a disk controller board: I/O slave decode, bus
  mastering with address latches, DMA handshake conversion, routing
  and the disk-side separator glue.
  Assumes all pins are synchronous to CLK_I and an APB master.
*/
// Added by the designer: the APB register port and the placing of the registers.
// Contract
// - The controller chip select is asserted only for host I/O addresses 100h to 110h.
// - The four low host address bits go to the controller as register select.
// - When mastering, the controller's data and commands reach the host bus directly; data goes through a one-clock register each way, commands do not.
// - The host address is latched from the muxed address/data bus when mastering.
// - Only 16-bit word transfers are made; no byte lane steering exists.
// - The controller's request/grant pair is translated to the host DMA handshake.
// - Request/acknowledge route to DMA channel 5, 6 or 7, the interrupt to 14, 6 or none.
// - The separator mode follows the controller's high drive select bit.
// - The separator clock is 5 MHz for hard disks and 4 MHz for floppies.
// - The separator clock is the 5 MHz source or the 8 MHz source halved.
// - One of three read data inputs is chosen for the selected drive.
// - A two-to-four decoder makes four exclusive drive selects.
// - Drives 0 and 1 map to hard disk selects one and two.
// - Drives 2 and 3 map to floppy selects zero and one.
// - The controller requests the bus first and moves data only once granted.
`timescale 1ns/1ps
`default_nettype none

module hbd_glue (
  input  wire logic                 CLK_I,
  input  wire logic                 RST_I,
  input  wire hbd_pkg::hbd_apb_req_t APB_REQ_I,
  output logic [31:0]               PRDATA_O,
  output logic                      PREADY_O,
  output logic                      PSLVERR_O,
  input  wire logic [9:0]           SA_I,
  input  wire logic                 AEN_I,
  input  wire logic                 IOR_N_I,
  input  wire logic                 IOW_N_I,
  output logic                      CS_N_O,
  output logic [3:0]                REG_ADDR_O,
  input  wire logic [15:0]          MAD_I,
  output logic [15:0]               MAD_O,
  output logic                      MAD_OE_N_O,
  input  wire logic                 CTL_ALE_I,
  input  wire logic                 CTL_UALE_I,
  input  wire logic                 CTL_RD_N_I,
  input  wire logic                 CTL_WR_N_I,
  input  wire logic                 CTL_BREQ_I,
  output logic                      CTL_BGNT_O,
  input  wire logic                 CTL_INT_I,
  output logic [2:0]                DREQ_O,
  input  wire logic [2:0]           DACK_N_I,
  output logic                      IRQ14_O,
  output logic                      IRQ6_O,
  output logic [23:0]               HA_O,
  output logic                      HA_OE_N_O,
  input  wire logic [15:0]          HD_I,
  output logic [15:0]               HD_O,
  output logic                      HD_OE_N_O,
  output logic                      MEMR_N_O,
  output logic                      MEMW_N_O,
  output logic                      SBHE_N_O,
  output logic                      CMD_OE_N_O,
  input  wire logic                 OSC5_I,
  input  wire logic                 OSC8_I,
  input  wire logic [1:0]           DRV_NUM_I,
  input  wire logic                 DRV_EN_I,
  input  wire logic [1:0]           RD_HD_I,
  input  wire logic                 RD_FD_I,
  output logic                      SEP_CLK_O,
  output logic                      SEP_FLOPPY_O,
  output logic                      SEP_RD_O,
  output logic [1:0]                HDD_SEL_O,
  output logic [1:0]                FDD_SEL_O
);
  import hbd_pkg::*;

  hbd_cfg_t    cfg_ff;
  hbd_state_t  st_ff;
  hbd_state_t  nxt_st;
  logic [31:0] prdata_ff;
  logic [23:0] addr_ff;
  logic [15:0] hd_o_ff;
  logic [15:0] mad_o_ff;
  logic        sep_floppy;

  // APB decode; the slave never inserts wait states.
  wire apb_setup = APB_REQ_I.psel & ~APB_REQ_I.penable;
  wire apb_acc   = APB_REQ_I.psel & APB_REQ_I.penable;
  wire hit_cfg   = APB_REQ_I.paddr == CFG_OFS;
  wire hit_stat  = APB_REQ_I.paddr == STAT_OFS;
  wire hit_any   = hit_cfg | hit_stat;
  wire cfg_wr    = apb_acc & APB_REQ_I.pwrite & hit_cfg;

  // Host I/O slave decode. AEN high marks a DMA cycle, which never selects.
  wire io_hit = ~AEN_I & (SA_I >= IO_WIN_LO) & (SA_I <= IO_WIN_HI);
  wire io_rd  = io_hit & ~IOR_N_I;
  wire io_wr  = io_hit & ~IOW_N_I;

  // Channel routing; the unused fourth code leaves every channel idle.
  wire [3:0] ch_dec   = hbd_dec24(1'b1, cfg_ff.dma_sel);
  wire       ch_ok    = ~ch_dec[3];
  wire       dack_hit = |(ch_dec[2:0] & ~DACK_N_I);
  wire       own      = st_ff == ST_OWN;
  wire       busy     = st_ff != ST_IDLE;

  wire [31:0] stat_word = 32'({io_hit, sep_floppy, DRV_NUM_I, st_ff});
  wire [31:0] rd_word   = hit_cfg ? 32'(cfg_ff) : (hit_stat ? stat_word : 32'h0000_0000);

  // Request/grant to DMA handshake. A request dropped before the host
  // acknowledges simply withdraws DREQ without ever granting.
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (CTL_BREQ_I && cfg_ff.mst_en && ch_ok) begin
          nxt_st = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!CTL_BREQ_I) begin
          nxt_st = ST_IDLE;
        end else if (dack_hit) begin
          nxt_st = ST_OWN;
        end
      end
      ST_OWN: begin
        if (!CTL_BREQ_I) begin
          nxt_st = ST_IDLE;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  // State, configuration and APB read data.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_ff     <= ST_IDLE;
      cfg_ff    <= CFG_RST;
      prdata_ff <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
      if (cfg_wr) begin
        cfg_ff <= hbd_cfg_t'(APB_REQ_I.pwdata[CFG_W-1:0]);
      end
      if (apb_setup && !APB_REQ_I.pwrite) begin
        prdata_ff <= rd_word;
      end
    end
  end

  // Address latches: low word on one strobe, high byte on the other, so
  // the address holds while data later shares the muxed bus.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      addr_ff <= 24'h00_0000;
    end else begin
      if (CTL_ALE_I) begin
        addr_ff[15:0] <= MAD_I;
      end
      if (CTL_UALE_I) begin
        addr_ff[23:16] <= MAD_I[7:0];
      end
    end
  end

  // Word-wide data buffers in each direction; no byte lane swap exists.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      hd_o_ff  <= 16'h0000;
      mad_o_ff <= 16'h0000;
    end else begin
      hd_o_ff  <= MAD_I;
      mad_o_ff <= HD_I;
    end
  end

  // APB answers.
  assign PRDATA_O  = prdata_ff;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = apb_acc & ~hit_any;

  // Slave side toward the controller.
  assign CS_N_O     = ~io_hit;
  assign REG_ADDR_O = SA_I[3:0];
  assign MAD_O      = mad_o_ff;
  assign MAD_OE_N_O = ~(io_wr | (own & ~CTL_RD_N_I));

  // Handshake and routing toward the host.
  assign CTL_BGNT_O = own;
  assign DREQ_O     = busy ? ch_dec[2:0] : 3'h0;
  assign IRQ14_O    = CTL_INT_I & (cfg_ff.irq_sel == IRQ_14);
  assign IRQ6_O     = CTL_INT_I & (cfg_ff.irq_sel == IRQ_6);

  // Master side: lines driven only while the bus is owned, except the data lines, which slave I/O reads also drive.
  assign HA_O       = addr_ff;
  assign HA_OE_N_O  = ~own;
  assign HD_O       = hd_o_ff;
  assign HD_OE_N_O  = ~(io_rd | (own & ~CTL_WR_N_I));
  assign MEMR_N_O   = ~(own & ~CTL_RD_N_I);
  assign MEMW_N_O   = ~(own & ~CTL_WR_N_I);
  assign SBHE_N_O   = ~own;
  assign CMD_OE_N_O = ~own;

  hbd_sep_ctl u_sep (
    .clk_i        (CLK_I),
    .rst_i        (RST_I),
    .osc5_i       (OSC5_I),
    .osc8_i       (OSC8_I),
    .drv_num_i    (DRV_NUM_I),
    .drv_en_i     (DRV_EN_I),
    .rd_hd_i      (RD_HD_I),
    .rd_fd_i      (RD_FD_I),
    .sep_clk_o    (SEP_CLK_O),
    .sep_floppy_o (sep_floppy),
    .sep_rd_o     (SEP_RD_O),
    .hdd_sel_o    (HDD_SEL_O),
    .fdd_sel_o    (FDD_SEL_O)
  );
  assign SEP_FLOPPY_O = sep_floppy;

  // Checks on decode, latching, handshake and bus release.
  cs_window_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !CS_N_O |-> !AEN_I && SA_I >= 10'h100 && SA_I <= 10'h110)
    else $error("chip select outside host I/O window");
  reg_addr_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !CS_N_O |-> REG_ADDR_O == SA_I[3:0])
    else $error("register select not from low address bits");
  data_drive_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    own && !CTL_WR_N_I |-> !HD_OE_N_O ##1 HD_O == $past(MAD_I))
    else $error("controller write data not on host bus");
  addr_latch_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    CTL_ALE_I |=> HA_O[15:0] == $past(MAD_I))
    else $error("host address not latched from muxed bus");
  word_only_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !CMD_OE_N_O |-> !SBHE_N_O)
    else $error("master cycle not marked as word");
  dreq_follow_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    st_ff == ST_IDLE && CTL_BREQ_I && cfg_ff.mst_en && ch_ok |=> DREQ_O != 3'h0)
    else $error("bus request not passed to host DMA");
  dreq_route_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    DREQ_O != 3'h0 |-> $onehot(DREQ_O) && !ch_dec[3])
    else $error("DMA request on wrong or several channels");
  irq_none_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    cfg_ff.irq_sel == IRQ_NONE |-> !IRQ14_O && !IRQ6_O)
    else $error("interrupt routed while set to none");
  grant_ack_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(CTL_BGNT_O) |-> $past(dack_hit) && $past(CTL_BREQ_I))
    else $error("grant without request and acknowledge");
  addr_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !CTL_ALE_I && !CTL_UALE_I |=> $stable(HA_O))
    else $error("host address moved without strobe");
  bus_release_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !CTL_BREQ_I |=> HA_OE_N_O && CMD_OE_N_O && !CTL_BGNT_O)
    else $error("host bus not released after request drop");

endmodule

`default_nettype wire

// ### test/hbd_host_dma.sv
/*
  Host DMA controller model for the disk board glue bench.
  Assumes active-low acknowledges and an answer lag chosen by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module hbd_host_dma (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] dreq_i,
  input  wire logic [3:0] lag_i,
  output logic      [2:0] dack_n_o
);
  logic [3:0] wait_ff;

  // Acknowledge after the chosen lag; a dropped request frees the channel at once.
  // A slow lag shows that the glue holds its request and keeps off the bus meanwhile.
  always @(posedge clk_i) begin
    if (rst_i || dreq_i == 3'h0) begin
      wait_ff  <= 4'h0;
      dack_n_o <= 3'h7;
    end else if (wait_ff >= lag_i) begin
      dack_n_o <= ~dreq_i;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### test/host_bus_disk_board_glue_bench.sv
/*
  Self-checking bench for the disk board host-bus glue.
  Assumes hbd_pkg is compiled first and the host DMA model sits beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module host_bus_disk_board_glue_bench;
  import hbd_pkg::*;
  typedef struct {int k; logic [31:0] v;} hbd_note_t;
  hbd_note_t    notes[$];
  hbd_note_t    n;
  hbd_apb_req_t APB_REQ_I;
  logic CLK_I, RST_I, AEN_I, IOR_N_I, IOW_N_I, CTL_ALE_I, CTL_UALE_I, CTL_RD_N_I, CTL_WR_N_I;
  logic CTL_BREQ_I, CTL_INT_I, OSC5_I, OSC8_I, DRV_EN_I, RD_FD_I, PREADY_O, PSLVERR_O, CS_N_O;
  logic MAD_OE_N_O, CTL_BGNT_O, IRQ14_O, IRQ6_O, HA_OE_N_O, HD_OE_N_O, MEMR_N_O, MEMW_N_O;
  logic SBHE_N_O, CMD_OE_N_O, SEP_CLK_O, SEP_FLOPPY_O, SEP_RD_O, hit, last;
  logic [1:0]  DRV_NUM_I, RD_HD_I, HDD_SEL_O, FDD_SEL_O, irq2;
  logic [2:0]  DACK_N_I, DREQ_O, onehot;
  logic [3:0]  REG_ADDR_O, lag, dec;
  logic [9:0]  SA_I;
  logic [9:0]  tbl [7] = '{10'h0ff, 10'h100, 10'h105, 10'h10f, 10'h110, 10'h111, 10'h105};
  logic [15:0] MAD_I, HD_I, MAD_O, HD_O;
  logic [23:0] HA_O;
  logic [31:0] PRDATA_O, v, seed = 32'h0000_32cd;
  int          failures = 0, comparisons = 0, i, k, c, tgl;

  hbd_glue u_hbd_glue (.*);
  hbd_host_dma u_hbd_host_dma (.clk_i(CLK_I), .rst_i(RST_I), .dreq_i(DREQ_O), .lag_i(lag),
                               .dack_n_o(DACK_N_I));

  // Free-running 100 MHz clock.
  always #5 CLK_I = ~CLK_I;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Kinds 7 and 8 are register results, kind 10 the clock toggle count, the rest are pin groups.
  function automatic logic [31:0] obs(input int kind);
    case (kind)
      0: obs = {27'h0, CS_N_O, REG_ADDR_O};
      1: obs = {26'h0, SEP_FLOPPY_O, SEP_RD_O, HDD_SEL_O, FDD_SEL_O};
      2: obs = {25'h0, DREQ_O, CTL_BGNT_O, HA_OE_N_O, IRQ14_O, IRQ6_O};
      3: obs = {8'h0, HA_O};
      4: obs = {16'h0, HD_O};
      5: obs = {16'h0, MAD_O};
      6: obs = {26'h0, CMD_OE_N_O, SBHE_N_O, MEMW_N_O, MEMR_N_O, HD_OE_N_O, MAD_OE_N_O};
      7: obs = {31'h0, PSLVERR_O};
      8: obs = PRDATA_O;
      9: obs = {31'h0, SEP_CLK_O};
      default: obs = tgl;
    endcase
  endfunction

  task automatic note(input int kind, input logic [31:0] val);
    notes.push_back('{kind, val});
  endtask

  task automatic cmp_pin(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH pin at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH register at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // One APB transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    @(posedge CLK_I);
    APB_REQ_I <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge CLK_I);
    APB_REQ_I.penable <= 1'b1;
    note(7, {31'h0, err});
    @(posedge CLK_I);
    while (PREADY_O !== 1'b1) @(posedge CLK_I);
    APB_REQ_I <= '0;
    if (!wr) note(8, exp);
  endtask

  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Every note is judged at the next falling edge, once outputs have settled.
  always @(negedge CLK_I) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      if (n.k == 7 || n.k == 8) cmp_reg(n.v, obs(n.k));
      else cmp_pin(n.v, obs(n.k));
    end
  end

  // A hung handshake must not stall the run; the whole sequence needs under 200 cycles.
  initial begin
    #200000;
    failures++;
    wrap_up();
  end

  // Main sequence: registers, slave decode, disk side, refused and granted bus requests.
  initial begin
    CLK_I = 1'b0;
    RST_I = 1'b1;
    APB_REQ_I = '0;
    {AEN_I, CTL_ALE_I, CTL_UALE_I, CTL_BREQ_I, CTL_INT_I, OSC5_I, OSC8_I, DRV_EN_I, RD_FD_I} = '0;
    {IOR_N_I, IOW_N_I, CTL_RD_N_I, CTL_WR_N_I} = '1;
    {SA_I, MAD_I, HD_I, DRV_NUM_I, RD_HD_I, lag} = '0;
    repeat (4) @(posedge CLK_I);
    RST_I <= 1'b0;
    CTL_INT_I <= 1'b1;
    apb(1'b0, 12'h000, '0, 32'h0000_0012, 1'b0);
    apb(1'b0, 12'h008, '0, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h004, 32'hffff_ffff, '0, 1'b0);
    apb(1'b0, 12'h000, '0, 32'h0000_0012, 1'b0);
    for (k = 0; k < 7; k++) begin
      @(posedge CLK_I);
      v = rnd();
      SA_I <= tbl[k];
      AEN_I <= (k == 6);
      IOR_N_I <= k[0];
      IOW_N_I <= !k[0];
      MAD_I <= v[15:0];
      HD_I <= v[31:16];
      hit = tbl[k] >= 10'h100 && tbl[k] <= 10'h110 && k != 6;
      note(0, {27'h0, !hit, tbl[k][3:0]});
      note(6, hit ? (k[0] ? 32'h0000_003e : 32'h0000_003d) : 32'h0000_003f);
      @(posedge CLK_I);
      if (hit) note(k[0] ? 5 : 4, k[0] ? v[31:16] : v[15:0]);
    end
    SA_I <= '0;
    {IOR_N_I, IOW_N_I, AEN_I} <= 3'b110;
    for (k = 0; k < 4; k++) begin
      @(posedge CLK_I);
      v = rnd();
      DRV_NUM_I <= k[1:0];
      DRV_EN_I <= 1'b1;
      RD_HD_I <= v[1:0];
      RD_FD_I <= v[2];
      OSC5_I <= v[3];
      // The observed group puts the two hard disk selects above the two floppy selects.
      dec = 4'h4 << k | 4'h4 >> (4 - k);
      @(posedge CLK_I);
      note(1, {26'h0, k[1], v[k < 2 ? k : 2], dec});
      if (k < 2) note(9, {31'h0, v[3]});
    end
    repeat (3) @(posedge CLK_I);
    @(negedge CLK_I);
    last = SEP_CLK_O;
    tgl = 0;
    for (c = 0; c < 24; c++) begin
      @(posedge CLK_I);
      OSC8_I <= c[1] && c < 16;
      @(negedge CLK_I);
      if (SEP_CLK_O !== last) tgl++;
      last = SEP_CLK_O;
    end
    note(10, 32'h0000_0004);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, 12'h000, k ? 32'h0000_0002 : 32'h0000_0013, '0, 1'b0);
      CTL_BREQ_I <= 1'b1;
      repeat (4) @(posedge CLK_I);
      note(2, 32'h0000_0004);
      CTL_BREQ_I <= 1'b0;
    end
    for (i = 0; i < 3; i++) begin
      onehot = 3'h1 << i;
      irq2 = {i == 1, i == 2};
      v = rnd();
      apb(1'b1, 12'h000, {27'h0, 1'b1, i[1:0], i[1:0]}, '0, 1'b0);
      apb(1'b0, 12'h000, '0, {27'h0, 1'b1, i[1:0], i[1:0]}, 1'b0);
      lag <= {i[1:0], 2'b00};
      CTL_BREQ_I <= 1'b1;
      @(posedge CLK_I);
      @(posedge CLK_I);
      note(2, {25'h0, onehot, 2'b01, irq2});
      note(6, 32'h0000_003f);
      while (CTL_BGNT_O !== 1'b1) @(negedge CLK_I);
      @(posedge CLK_I);
      note(2, {25'h0, onehot, 2'b10, irq2});
      note(6, 32'h0000_000f);
      apb(1'b0, 12'h004, '0, 32'h0000_003c, 1'b0);
      @(posedge CLK_I);
      MAD_I <= v[15:0];
      CTL_ALE_I <= 1'b1;
      @(posedge CLK_I);
      CTL_ALE_I <= 1'b0;
      CTL_UALE_I <= 1'b1;
      MAD_I <= {8'h00, v[23:16]};
      @(posedge CLK_I);
      CTL_UALE_I <= 1'b0;
      MAD_I <= ~v[15:0];
      CTL_WR_N_I <= 1'b0;
      note(3, {8'h0, v[23:0]});
      note(6, 32'h0000_0005);
      @(posedge CLK_I);
      CTL_WR_N_I <= 1'b1;
      CTL_RD_N_I <= 1'b0;
      HD_I <= v[31:16];
      note(4, {16'h0, ~v[15:0]});
      note(6, 32'h0000_000a);
      @(posedge CLK_I);
      CTL_RD_N_I <= 1'b1;
      CTL_BREQ_I <= 1'b0;
      note(5, {16'h0, v[31:16]});
      @(posedge CLK_I);
      note(2, {25'h0, 3'h0, 2'b01, irq2});
      note(3, {8'h0, v[23:0]});
      note(6, 32'h0000_003f);
      repeat (2) @(posedge CLK_I);
    end
    @(posedge CLK_I);
    @(negedge CLK_I);
    wrap_up();
  end
endmodule
`default_nettype wire
